// ===== mifc_consts.vh
`ifndef MIFC_CONSTS_VH
`define MIFC_CONSTS_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define MIFC_IDX_W 7
`define MIFC_IDX_FANDIV 7'h05
`define MIFC_IDX_STAT2 7'h42
`define MIFC_IDX_MASK2 7'h44

// ****************************************
// fan divider / pin function fields
// ****************************************
`define MIFC_FD_TA_LVL 0
`define MIFC_FD_TB_LVL 1
`define MIFC_FD_TA_DIV 2
`define MIFC_FD_TB_DIV 4
`define MIFC_FD_LVL_POL 2
`define MIFC_FD_OS_EN 6
`define MIFC_FD_RST_EN 7
`define MIFC_FD_UPPER_RST 4'h5

// ****************************************
// status / mask fields
// ****************************************
`define MIFC_ST_W 6
`define MIFC_ST_HOT 0
`define MIFC_ST_TA 2
`define MIFC_ST_TB 3
`define MIFC_ST_OS 5
`define MIFC_MK_HOT_MODE 6
`define MIFC_MK_OS_MODE 7
`define MIFC_MASK2_RST 8'h00
`define MIFC_STAT2_RST 6'h00

`endif

// ===== mifc_temp_flag.v
`timescale 1ns/100ps
// ****************************************
// temperature flag evaluator
// ****************************************
module mifc_temp_flag (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire conv_done_i,
    input wire above_i,
    input wire below_i,
    input wire one_time_i,
    output wire set_o,
    output wire hot_o
);
    reg hot_reg;
    reg hot_next;
    reg set_c;

    always @* begin
        hot_next = hot_reg;
        set_c = 1'b0;
        if (conv_done_i) begin
            if (above_i) begin
                hot_next = 1'b1;
            end else if (below_i) begin
                hot_next = 1'b0;
            end
            if (one_time_i) begin
                // only the crossings raise the flag
                set_c = (above_i & ~hot_reg) | (below_i & hot_reg);
            end else begin
                // re-raised every conversion until below hysteresis
                set_c = above_i | (hot_reg & ~below_i);
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            hot_reg <= 1'b0;
        end else if (ce_i) begin
            hot_reg <= hot_next;
        end
    end

    assign set_o = set_c & ce_i;
    assign hot_o = hot_reg;
endmodule

// ===== mifc_top.v
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - mask bit 5 blocks overtemp flag interrupt
// - default hot mode: re-raise each conversion
// - one-time hot mode: entry and exit once
// - one-time: read clears, no re-set
// - mask bit 7 selects overtemp mode
// - bit 0: tach a level or count
// - bit 1: tach b level or count
// - bits 3:2 tach a divide ratio
// - bits 5:4 tach b divide ratio
// - bit 2 sets level input polarity
// - bit 6 only: pin overtemp open-drain
// - bit 7: pin is reset output
// - bits 6,7 zero: pin disabled
// - reset loads 0101 and ident pins
// - overtemp output: comparator style only
`include "mifc_consts.vh"

module mifc_top #(
    parameter DIV_CNT_W = 3
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [8:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [3:0] voltage_ident_pins_i,
    input wire conv_done_i,
    input wire hot_above_i,
    input wire hot_below_hyst_i,
    input wire os_above_i,
    input wire os_below_hyst_i,
    input wire reset_request_i,
    input wire tach_input_a_i,
    input wire tach_input_b_i,
    output reg tach_a_count_pulse_o,
    output reg tach_b_count_pulse_o,
    output reg shared_reset_overtemp_pin_o,
    output reg shared_reset_overtemp_pin_oe_n_o,
    output reg overtemp_out_o,
    output reg irq_o
);

    // ****************************************
    // registers
    // ****************************************
    reg [7:0] fan_divider_and_pin_function_reg;
    reg [7:0] fan_divider_and_pin_function_next;
    reg [7:0] irq_mask_and_temp_irq_mode_reg;
    reg [7:0] irq_mask_and_temp_irq_mode_next;
    reg [`MIFC_ST_W-1:0] irq_status_reg;
    reg [`MIFC_ST_W-1:0] irq_status_next;
    reg [31:0] rd_data_next;
    reg ack_next;
    reg os_level_reg;
    reg os_level_next;

    wire [`MIFC_IDX_W-1:0] idx;
    wire req;
    wire wr_take;
    wire rd_take;
    wire hot_set;
    wire os_set;
    wire [1:0] tach_in;
    wire [1:0] lvl_mode;
    wire [1:0] lvl_active;
    wire [1:0] cnt_pulse;
    wire [1:0] ratio [0:1];
    wire lvl_pol_low;
    wire [1:0] pin_mode;

    assign idx = wb_adr_i[8:2];
    // one request per ack; the cycle that carries ack is never taken again
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_take = req & wb_we_i & wb_sel_i[0];
    assign rd_take = req & ~wb_we_i;

    // ****************************************
    // temperature flags
    // ****************************************
    mifc_temp_flag u_hot_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .conv_done_i(conv_done_i),
        .above_i(hot_above_i),
        .below_i(hot_below_hyst_i),
        .one_time_i(irq_mask_and_temp_irq_mode_reg[`MIFC_MK_HOT_MODE]),
        .set_o(hot_set),
        .hot_o()
    );

    // same mode machinery, selected by mask bit 7
    mifc_temp_flag u_os_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .conv_done_i(conv_done_i),
        .above_i(os_above_i),
        .below_i(os_below_hyst_i),
        .one_time_i(irq_mask_and_temp_irq_mode_reg[`MIFC_MK_OS_MODE]),
        .set_o(os_set),
        .hot_o()
    );

    // comparator style: level follows last conversion's limit result
    always @* begin
        os_level_next = os_level_reg;
        if (conv_done_i) begin
            os_level_next = os_above_i;
        end
    end

    // ****************************************
    // tachometer inputs
    // ****************************************
    assign tach_in = {tach_input_b_i, tach_input_a_i};
    assign lvl_mode[0] = fan_divider_and_pin_function_reg[`MIFC_FD_TA_LVL];
    assign lvl_mode[1] = fan_divider_and_pin_function_reg[`MIFC_FD_TB_LVL];
    assign ratio[0] = fan_divider_and_pin_function_reg[`MIFC_FD_TA_DIV+1:`MIFC_FD_TA_DIV];
    assign ratio[1] = fan_divider_and_pin_function_reg[`MIFC_FD_TB_DIV+1:`MIFC_FD_TB_DIV];
    // one polarity bit serves both inputs; it overlaps the ratio field
    assign lvl_pol_low = fan_divider_and_pin_function_reg[`MIFC_FD_LVL_POL];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_tach
            reg prev_reg;
            reg [DIV_CNT_W-1:0] edge_cnt_reg;
            reg [DIV_CNT_W-1:0] edge_cnt_next;
            reg pulse_c;
            wire [DIV_CNT_W-1:0] terminal;

            // divide by 1, 2, 4, 8 for codes 00..11
            assign terminal = (({{(DIV_CNT_W-1){1'b0}}, 1'b1}) << ratio[g])
                - {{(DIV_CNT_W-1){1'b0}}, 1'b1};

            always @* begin
                edge_cnt_next = edge_cnt_reg;
                pulse_c = 1'b0;
                if (lvl_mode[g]) begin
                    edge_cnt_next = {DIV_CNT_W{1'b0}};
                end else if (tach_in[g] & ~prev_reg) begin
                    if (edge_cnt_reg >= terminal) begin
                        edge_cnt_next = {DIV_CNT_W{1'b0}};
                        pulse_c = 1'b1;
                    end else begin
                        edge_cnt_next = edge_cnt_reg + {{(DIV_CNT_W-1){1'b0}}, 1'b1};
                    end
                end
            end

            always @(posedge clk_i) begin
                if (rst_i) begin
                    prev_reg <= 1'b0;
                    edge_cnt_reg <= {DIV_CNT_W{1'b0}};
                end else if (ce_i) begin
                    prev_reg <= tach_in[g];
                    edge_cnt_reg <= edge_cnt_next;
                end
            end

            assign cnt_pulse[g] = pulse_c;
            // active low when polarity bit set, else active high
            assign lvl_active[g] = lvl_mode[g] & (tach_in[g] ^ lvl_pol_low);
        end
    endgenerate

    // ****************************************
    // status flags
    // ****************************************
    always @* begin
        irq_status_next = irq_status_reg;
        // a read clears; a same-cycle set still wins below
        if (rd_take && idx == `MIFC_IDX_STAT2) begin
            irq_status_next = `MIFC_STAT2_RST;
        end
        if (hot_set) begin
            irq_status_next[`MIFC_ST_HOT] = 1'b1;
        end
        if (os_set) begin
            irq_status_next[`MIFC_ST_OS] = 1'b1;
        end
        if (lvl_active[0]) begin
            irq_status_next[`MIFC_ST_TA] = 1'b1;
        end
        if (lvl_active[1]) begin
            irq_status_next[`MIFC_ST_TB] = 1'b1;
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    always @* begin
        fan_divider_and_pin_function_next = fan_divider_and_pin_function_reg;
        irq_mask_and_temp_irq_mode_next = irq_mask_and_temp_irq_mode_reg;
        if (wr_take) begin
            case (idx)
                `MIFC_IDX_FANDIV: begin
                    fan_divider_and_pin_function_next = wb_dat_i[7:0];
                end
                `MIFC_IDX_MASK2: begin
                    irq_mask_and_temp_irq_mode_next = wb_dat_i[7:0];
                end
                default: begin
                    fan_divider_and_pin_function_next = fan_divider_and_pin_function_reg;
                end
            endcase
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    always @* begin
        rd_data_next = 32'h0000_0000;
        ack_next = req;
        if (rd_take) begin
            case (idx)
                `MIFC_IDX_FANDIV: begin
                    rd_data_next[7:0] = fan_divider_and_pin_function_reg;
                end
                `MIFC_IDX_MASK2: begin
                    rd_data_next[7:0] = irq_mask_and_temp_irq_mode_reg;
                end
                `MIFC_IDX_STAT2: begin
                    rd_data_next[`MIFC_ST_W-1:0] = irq_status_reg;
                end
                default: begin
                    // unmapped: acked, reads zero
                    rd_data_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************
    // shared reset / overtemp pin
    // ****************************************
    assign pin_mode = {fan_divider_and_pin_function_reg[`MIFC_FD_RST_EN],
        fan_divider_and_pin_function_reg[`MIFC_FD_OS_EN]};

    // ****************************************
    // register state
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            // sync reset, so sampling the ident pins here is safe
            fan_divider_and_pin_function_reg <= {`MIFC_FD_UPPER_RST,
                voltage_ident_pins_i};
            irq_mask_and_temp_irq_mode_reg <= `MIFC_MASK2_RST;
            irq_status_reg <= `MIFC_STAT2_RST;
            os_level_reg <= 1'b0;
        end else if (ce_i) begin
            // hardware sets status, the bus only ever clears it
            fan_divider_and_pin_function_reg <= fan_divider_and_pin_function_next;
            irq_mask_and_temp_irq_mode_reg <= irq_mask_and_temp_irq_mode_next;
            irq_status_reg <= irq_status_next;
            os_level_reg <= os_level_next;
        end
    end

    // ****************************************
    // bus answer
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            // ce low stalls the answer as well, so the master just waits
            wb_ack_o <= ack_next;
            wb_dat_o <= rd_data_next;
        end
    end

    // ****************************************
    // tachometer count pulses
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            tach_a_count_pulse_o <= 1'b0;
            tach_b_count_pulse_o <= 1'b0;
        end else if (ce_i) begin
            // registered, so a pulse trails its input edge by one cycle
            tach_a_count_pulse_o <= cnt_pulse[0];
            tach_b_count_pulse_o <= cnt_pulse[1];
        end
    end

    // ****************************************
    // interrupt line
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            // next values, so the line moves in the same cycle as the status bit
            // mask bit set keeps that flag off the interrupt line
            irq_o <= |(irq_status_next
                & ~irq_mask_and_temp_irq_mode_next[`MIFC_ST_W-1:0]);
        end
    end

    // ****************************************
    // overtemp level and shared pin
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            overtemp_out_o <= 1'b0;
            shared_reset_overtemp_pin_o <= 1'b0;
            shared_reset_overtemp_pin_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            // comparator style: follows the last conversion, no latching
            overtemp_out_o <= os_level_next;
            // open drain: only ever pulls low
            shared_reset_overtemp_pin_o <= 1'b0;
            // the pin mode acts one edge after the register write
            case (pin_mode)
                2'b01: begin
                    shared_reset_overtemp_pin_oe_n_o <= ~os_level_next;
                end
                2'b10, 2'b11: begin
                    // reset mode wins whatever bit 6 says
                    shared_reset_overtemp_pin_oe_n_o <= ~reset_request_i;
                end
                default: begin
                    shared_reset_overtemp_pin_oe_n_o <= 1'b1;
                end
            endcase
        end
    end

endmodule

// ===== mifc_chk.sv
`timescale 1ns/100ps
`include "mifc_consts.vh"
module mifc_chk (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [8:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire [3:0] voltage_ident_pins_i,
    input wire conv_done_i,
    input wire os_above_i,
    input wire reset_request_i,
    input wire tach_a_count_pulse_o,
    input wire shared_reset_overtemp_pin_o,
    input wire shared_reset_overtemp_pin_oe_n_o,
    input wire overtemp_out_o,
    input wire irq_o
);
    // ****************************************
    // shadow registers, written at the take edge
    // ****************************************
    reg [7:0] mask_reg;
    reg [7:0] fan_reg;
    wire wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i && wb_sel_i[0];
    always @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= `MIFC_MASK2_RST;
            fan_reg <= {`MIFC_FD_UPPER_RST, voltage_ident_pins_i};
        end else if (wr_take && wb_adr_i[8:2] == `MIFC_IDX_MASK2) begin
            mask_reg <= wb_dat_i[7:0];
        end else if (wr_take && wb_adr_i[8:2] == `MIFC_IDX_FANDIV) begin
            fan_reg <= wb_dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ****************************************
    // properties
    // ****************************************
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("no ack one cycle after request");
    AST_OS_MASK: assert property (mask_reg[5] && mask_reg[3:2] == 2'b11 && mask_reg[0] |-> !irq_o)
        else $error("irq with all sources masked");
    AST_PIN_DRV: assert property (!shared_reset_overtemp_pin_o)
        else $error("open drain pin driven high");
    AST_PIN_OS: assert property (fan_reg[7:6] == 2'b01 && !conv_done_i |=>
        shared_reset_overtemp_pin_oe_n_o == !overtemp_out_o) else $error("pin not following overtemp");
    AST_PIN_RST: assert property (fan_reg[7] && reset_request_i |=> !shared_reset_overtemp_pin_oe_n_o)
        else $error("reset request not on pin");
    AST_PIN_OFF: assert property (fan_reg[7:6] == 2'b00 |=> shared_reset_overtemp_pin_oe_n_o)
        else $error("disabled pin pulled low");
    AST_OS_LEVEL: assert property (conv_done_i && ce_i |=> overtemp_out_o == $past(os_above_i))
        else $error("overtemp level not comparator");
    AST_PULSE_A: assert property (tach_a_count_pulse_o |=> !tach_a_count_pulse_o)
        else $error("count pulse longer than one cycle");
    COV_IRQ: cover property ($rose(irq_o));
    COV_OS: cover property (conv_done_i && os_above_i);
    COV_TACH: cover property (tach_a_count_pulse_o);
endmodule

bind mifc_top mifc_chk u_mifc_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .voltage_ident_pins_i, .conv_done_i,
    .os_above_i, .reset_request_i, .tach_a_count_pulse_o, .shared_reset_overtemp_pin_o,
    .shared_reset_overtemp_pin_oe_n_o, .overtemp_out_o, .irq_o);

// ===== mifc_host.sv
`timescale 1ns/100ps
module mifc_host (
    input wire clk_i,
    input wire wb_ack_i,
    input wire [31:0] wb_dat_i,
    output reg wb_cyc_o = 1'b0,
    output reg wb_stb_o = 1'b0,
    output reg wb_we_o = 1'b0,
    output reg [8:0] wb_adr_o = 9'h000,
    output reg [3:0] wb_sel_o = 4'hf,
    output reg [31:0] wb_dat_o = 32'h0000_0000
);
    // status clears on read, so every event is fetched by one read
    task xfer(input w, input [6:0] idx, input [7:0] d, output [31:0] q);
        begin
            wb_cyc_o <= 1'b1;
            wb_stb_o <= 1'b1;
            wb_we_o <= w;
            wb_adr_o <= {idx, 2'b00};
            wb_dat_o <= {24'h00_0000, d};
            @(posedge clk_i);
            while (wb_ack_i !== 1'b1)
                @(posedge clk_i);
            q = wb_dat_i;
            wb_cyc_o <= 1'b0;
            wb_stb_o <= 1'b0;
            @(posedge clk_i);
        end
    endtask
endmodule

// ===== mifc_tb.sv
`timescale 1ns/100ps
`include "mifc_consts.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("wrong value %0t got %h exp %h", $time, g, e); end end
module testbench;
    reg clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, conv_done_i = 1'b0, reset_request_i = 1'b0;
    reg hot_above_i = 1'b0, hot_below_hyst_i = 1'b0, os_above_i = 1'b0, os_below_hyst_i = 1'b0;
    reg tach_input_a_i = 1'b0, tach_input_b_i = 1'b0;
    reg [3:0] voltage_ident_pins_i = 4'h9;
    wire wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tach_a_count_pulse_o, tach_b_count_pulse_o;
    wire shared_reset_overtemp_pin_o, shared_reset_overtemp_pin_oe_n_o, overtemp_out_o, irq_o;
    wire [8:0] wb_adr_i;
    wire [3:0] wb_sel_i;
    wire [31:0] wb_dat_i, wb_dat_o;
    reg [31:0] q;
    integer errors = 0, checked = 0, cycles = 0;
    mifc_top u_mifc_top (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .voltage_ident_pins_i, .conv_done_i,
        .hot_above_i, .hot_below_hyst_i, .os_above_i, .os_below_hyst_i, .reset_request_i,
        .tach_input_a_i, .tach_input_b_i, .tach_a_count_pulse_o, .tach_b_count_pulse_o,
        .shared_reset_overtemp_pin_o, .shared_reset_overtemp_pin_oe_n_o, .overtemp_out_o, .irq_o);
    mifc_host u_mifc_host (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o),
        .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
        .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task conclude;
        begin
            if (errors == 0 && checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task wr(input [6:0] idx, input [7:0] d);
        u_mifc_host.xfer(1'b1, idx, d, q);
    endtask
    task rd(input [6:0] idx, input [7:0] e);
        begin
            u_mifc_host.xfer(1'b0, idx, 8'h00, q);
            `CHK(q, {24'h00_0000, e})
        end
    endtask
    task conv(input ha, hb, oa, ob);
        begin
            conv_done_i <= 1'b1;
            hot_above_i <= ha;
            hot_below_hyst_i <= hb;
            os_above_i <= oa;
            os_below_hyst_i <= ob;
            @(posedge clk_i);
            conv_done_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        begin
            rd(`MIFC_IDX_FANDIV, 8'h59);
            rd(`MIFC_IDX_MASK2, 8'h00);
            wr(`MIFC_IDX_FANDIV, 8'h9c);
            rd(`MIFC_IDX_FANDIV, 8'h9c);
            wr(`MIFC_IDX_MASK2, 8'h3c);
            rd(`MIFC_IDX_MASK2, 8'h3c);
            wr(7'h7f, 8'hff);
            rd(7'h7f, 8'h00);
        end
    endtask
    task t_hot;
        begin
            wr(`MIFC_IDX_MASK2, 8'h00);
            conv(1'b1, 1'b0, 1'b0, 1'b0);
            `CHK(irq_o, 1'b1)
            rd(`MIFC_IDX_STAT2, 8'h01);
            `CHK(irq_o, 1'b0)
            conv(1'b0, 1'b0, 1'b0, 1'b0);
            rd(`MIFC_IDX_STAT2, 8'h01);
            conv(1'b0, 1'b1, 1'b0, 1'b0);
            rd(`MIFC_IDX_STAT2, 8'h00);
            wr(`MIFC_IDX_MASK2, 8'h40);
            conv(1'b1, 1'b0, 1'b0, 1'b0);
            rd(`MIFC_IDX_STAT2, 8'h01);
            conv(1'b1, 1'b0, 1'b0, 1'b0);
            rd(`MIFC_IDX_STAT2, 8'h00);
            conv(1'b0, 1'b1, 1'b0, 1'b0);
            rd(`MIFC_IDX_STAT2, 8'h01);
            conv(1'b0, 1'b1, 1'b0, 1'b0);
            rd(`MIFC_IDX_STAT2, 8'h00);
        end
    endtask
    task t_os;
        begin
            wr(`MIFC_IDX_MASK2, 8'had);
            conv(1'b0, 1'b0, 1'b1, 1'b0);
            `CHK(irq_o, 1'b0)
            `CHK(overtemp_out_o, 1'b1)
            rd(`MIFC_IDX_STAT2, 8'h20);
            conv(1'b0, 1'b0, 1'b1, 1'b0);
            rd(`MIFC_IDX_STAT2, 8'h00);
            wr(`MIFC_IDX_MASK2, 8'h00);
            conv(1'b0, 1'b0, 1'b1, 1'b0);
            `CHK(irq_o, 1'b1)
            rd(`MIFC_IDX_STAT2, 8'h20);
            conv(1'b0, 1'b0, 1'b0, 1'b1);
            `CHK(overtemp_out_o, 1'b0)
            rd(`MIFC_IDX_STAT2, 8'h00);
        end
    endtask
    // a conversion while ce is low must leave every flag and level untouched
    task t_ce;
        begin
            ce_i <= 1'b0;
            conv(1'b1, 1'b0, 1'b1, 1'b0);
            `CHK(overtemp_out_o, 1'b0)
            `CHK(irq_o, 1'b0)
            ce_i <= 1'b1;
            rd(`MIFC_IDX_STAT2, 8'h00);
        end
    endtask
    task t_pin;
        begin
            wr(`MIFC_IDX_FANDIV, 8'h40);
            `CHK(shared_reset_overtemp_pin_oe_n_o, 1'b1)
            conv(1'b0, 1'b0, 1'b1, 1'b0);
            @(posedge clk_i);
            `CHK(shared_reset_overtemp_pin_oe_n_o, 1'b0)
            wr(`MIFC_IDX_FANDIV, 8'h00);
            `CHK(shared_reset_overtemp_pin_oe_n_o, 1'b1)
            reset_request_i <= 1'b1;
            wr(`MIFC_IDX_FANDIV, 8'hc0);
            `CHK(shared_reset_overtemp_pin_oe_n_o, 1'b0)
            reset_request_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            `CHK(shared_reset_overtemp_pin_oe_n_o, 1'b1)
            conv(1'b0, 1'b0, 1'b0, 1'b1);
        end
    endtask
    task t_tach;
        integer r, i, na, nb;
        begin
            for (r = 0; r < 4; r++) begin
                wr(`MIFC_IDX_FANDIV, {2'b00, r[1:0], r[1:0], 2'b00});
                na = 0;
                nb = 0;
                // eight rises, a multiple of every ratio, so no residue carries over
                for (i = 0; i < 36; i++) begin
                    tach_input_a_i <= (i < 32) & i[1];
                    tach_input_b_i <= (i < 32) & i[1];
                    @(posedge clk_i);
                    na = na + tach_a_count_pulse_o;
                    nb = nb + tach_b_count_pulse_o;
                end
                `CHK(na, 8 >> r)
                `CHK(nb, 8 >> r)
            end
        end
    endtask
    task t_level;
        integer p;
        begin
            for (p = 0; p < 2; p++) begin
                wr(`MIFC_IDX_FANDIV, {5'h00, p[0], 2'b11});
                tach_input_a_i <= p[0];
                tach_input_b_i <= p[0];
                repeat (2) @(posedge clk_i);
                wr(`MIFC_IDX_MASK2, 8'h00);
                u_mifc_host.xfer(1'b0, `MIFC_IDX_STAT2, 8'h00, q);
                tach_input_a_i <= !p[0];
                tach_input_b_i <= !p[0];
                repeat (3) @(posedge clk_i);
                `CHK(irq_o, 1'b1)
                rd(`MIFC_IDX_STAT2, 8'h0c);
                tach_input_a_i <= p[0];
                tach_input_b_i <= p[0];
                repeat (2) @(posedge clk_i);
                u_mifc_host.xfer(1'b0, `MIFC_IDX_STAT2, 8'h00, q);
                rd(`MIFC_IDX_STAT2, 8'h00);
            end
        end
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            conclude;
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_hot;
        t_os;
        t_ce;
        t_pin;
        t_tach;
        t_level;
        conclude;
    end
endmodule
